/* File: rtl/spla_pkg.sv */
package spla_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses, one 32-bit word each)
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_TXD = 8'h08;
   localparam logic [7:0] REG_RXD = 8'h0c;

   // Status bit positions, then the control-tag bit of a TXD word
   localparam int ST_BUSY = 0;
   localparam int ST_HOLD = 1;
   localparam int ST_RXV = 2;
   localparam int ST_PERR = 3;
   localparam int ST_OVR = 4;
   localparam int ST_TMO = 5;
   localparam int ST_SPDBAD = 6;
   localparam int ST_DTR = 7;
   localparam int ST_RTS = 8;
   localparam int ST_TEXT = 9;
   localparam int TXD_CTL = 8;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] speed;
      logic cts_en;
      logic rx_par_chk;
      logic par_odd;
      logic seven;
      logic transp;
      logic bisync;
      logic enable;
   } spla_ctrl_t;

   typedef struct packed {
      logic ctl;
      logic [7:0] data;
   } spla_txw_t;

   typedef enum logic [2:0] {
      TX_IDLE, TX_LEAD, TX_RUN, TX_ESC, TX_FILL, TX_CRC1, TX_CRC2
   } spla_txst_t;

   // Reset values: disabled, async, 9600 bps
   localparam logic [9:0] CTRL_RST = 10'h300;
   localparam logic [2:0] PIN_RST = 3'h1;
   localparam logic [15:0] CRC_INIT = 16'h0000;
   localparam logic [15:0] CRC_POLY_REV = 16'ha001;

   // ----------------------------------------------------------------
   // Link characters and framing
   // ----------------------------------------------------------------
   localparam logic [7:0] SYN_CH = 8'h32;
   localparam logic [7:0] STX_CH = 8'h02;
   localparam logic [7:0] ETX_CH = 8'h03;
   localparam logic [7:0] ETB_CH = 8'h26;
   localparam logic [7:0] EOT_CH = 8'h37;
   localparam logic [7:0] DLE_CH = 8'h10;
   localparam logic [7:0] ENQ_CH = 8'h2d;
   localparam logic [7:0] PAD_CH = 8'hff;
   localparam int LEAD_SYNS = 4;
   localparam logic [3:0] LEN_BSC = 4'h8;
   localparam logic [3:0] LEN_A7 = 4'ha;
   localparam logic [3:0] LEN_A8 = 4'hb;
   localparam logic [3:0] RXB_A7 = 4'h8;
   localparam logic [3:0] RXB_A8 = 4'h9;
   localparam logic [2:0] BSC_LAST = 3'h7;

   // Speed codes
   localparam logic [2:0] SPD_600 = 3'h2;
   localparam logic [2:0] SPD_19200 = 3'h7;

   function automatic int spla_rate(input logic [2:0] code);
      case (code)
         3'h0: spla_rate = 150;
         3'h1: spla_rate = 300;
         3'h2: spla_rate = 600;
         3'h3: spla_rate = 1200;
         3'h4: spla_rate = 2400;
         3'h5: spla_rate = 4800;
         3'h6: spla_rate = 9600;
         default: spla_rate = 19200;
      endcase
   endfunction : spla_rate

endpackage : spla_pkg

/* File: rtl/spla_bitclk.sv */
`timescale 1ns/10ps
module spla_bitclk
   import spla_pkg::*;
(
   // System
   input wire logic clk_i,
   input wire logic rst_i,
   // Half period in system clocks
   input wire logic [23:0] half_i,
   // Bit clock and its edges
   output logic bclk_o,
   output logic rise_o,
   output logic fall_o
);

   logic [23:0] cnt;
   wire wrap = (cnt >= half_i - 24'h1);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= 24'h0;
         bclk_o <= 1'b1;
         rise_o <= 1'b0;
         fall_o <= 1'b0;
      end else begin
         cnt <= wrap ? 24'h0 : cnt + 24'h1;
         bclk_o <= wrap ? !bclk_o : bclk_o;
         rise_o <= wrap && !bclk_o;
         fall_o <= wrap && bclk_o;
      end
   end

endmodule : spla_bitclk

/* File: rtl/spla_crc16.sv */
`timescale 1ns/10ps
module spla_crc16
   import spla_pkg::*;
(
   // System
   input wire logic clk_i,
   input wire logic rst_i,
   // Accumulation control
   input wire logic clr_i,
   input wire logic upd_i,
   input wire logic [7:0] byte_i,
   // Result
   output logic [15:0] crc_o
);

   // Bits enter least significant first, as they go on the line
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC_POLY_REV) : (r >> 1);
      end
      crc_step = r;
   endfunction : crc_step

   always_ff @(posedge clk_i) begin
      if (rst_i || clr_i) begin
         crc_o <= CRC_INIT;
      end else if (upd_i) begin
         crc_o <= crc_step(crc_o, byte_i);
      end
   end

endmodule : spla_crc16

/* File: rtl/spla_adapter.sv */
// Behaviour
// RULE1 - Far end holds its data line toward us at mark when idle.
// RULE2 - Our outgoing data line sits at mark whenever no character is sent.
// RULE3 - We drive a transmit bit clock; every outgoing bit is timed by it.
// RULE4 - We drive a receive bit clock; incoming bits are sampled with it.
// RULE5 - Far end raises terminal ready when able; honouring it is optional.
// RULE6 - Far end raises request to send when it has data for us.
// RULE7 - Clear to send only follows request to send; dropped to hold off.
// RULE8 - Transmit async or bisync; receive async, bisync responses only.
// RULE9 - Bisync responses pass unchecked to software; no block reception.
// RULE10 - Every bisync transmission starts with four sync characters.
// RULE11 - After a bisync transmission the line stays at mark.
// RULE12 - Data gaps inside a block are filled with sync pairs.
// RULE13 - Far end discards sync fill characters.
// RULE14 - Check runs after start-of-text through terminator, sent right after.
// RULE15 - Sync, pad, inserted escapes and fill are kept out of the check.
// RULE16 - No response after a transmission raises a time-out error.
// RULE17 - Transparent mode puts an escape before each true control character.
// RULE18 - Transparent mode sends a text escape byte as two escapes.
// RULE19 - Far end drops the first of two escapes and keeps the second.
// RULE20 - Start, end, block end, end of transmission, escape, sync, enquiry known.
// RULE21 - Async transmit always adds parity; receive check is configurable.
// RULE22 - 7-bit async receive keeps the parity bit in the top bit.
// RULE23 - 150/300 async only, 600-9600 both, 19200 bisync only.
// RULE24 - Block check is CRC-16, x^16+x^15+x^2+1, two characters.
`timescale 1ns/10ps
module spla_adapter
   import spla_pkg::*;
#(
   parameter int CLK_HZ = 200_000_000,
   parameter int TIMEOUT_CYC = 200_000_000
) (
   // System
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Serial link
   output logic link_txd_o,
   input wire logic link_rxd_i,
   output logic link_txclk_o,
   output logic link_rxclk_o,
   input wire logic link_rts_i,
   input wire logic link_dtr_i,
   output logic link_cts_o
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] pin_meta;
   logic [2:0] pin_sync;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_meta <= PIN_RST;
         pin_sync <= PIN_RST;
      end else begin
         pin_meta <= {link_dtr_i, link_rts_i, link_rxd_i};
         pin_sync <= pin_meta;
      end
   end

   wire rxd_s = pin_sync[0];
   wire rts_s = pin_sync[1];
   wire dtr_s = pin_sync[2];

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   spla_ctrl_t cfg;
   spla_txw_t hold;
   logic hold_full;
   logic [7:0] rx_byte;
   logic rx_valid;
   logic perr_flag;
   logic ovr_flag;
   logic tmo_flag;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wb_wr = wb_req && wb_we_i;
   wire wr_ctrl = wb_wr && (wb_adr_i == REG_CTRL);
   wire wr_stat = wb_wr && (wb_adr_i == REG_STAT) && wb_sel_i[0];
   wire wr_txd = wb_wr && (wb_adr_i == REG_TXD) && wb_sel_i[0] && !hold_full;
   wire rd_rxd = wb_req && !wb_we_i && (wb_adr_i == REG_RXD);

   wire speed_ok = cfg.bisync ? (cfg.speed >= SPD_600) : (cfg.speed != SPD_19200); // RULE23
   wire tx_ok = cfg.enable && speed_ok;

   // ----------------------------------------------------------------
   // Bit clocks
   // ----------------------------------------------------------------
   wire [23:0] half = 24'(CLK_HZ / (2 * spla_rate(cfg.speed)));
   wire tx_fall;
   wire rx_rise;

   spla_bitclk u_txclk (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .half_i (half),
      .bclk_o (link_txclk_o),
      .rise_o (),
      .fall_o (tx_fall)
   );

   spla_bitclk u_rxclk (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .half_i (half),
      .bclk_o (link_rxclk_o),
      .rise_o (rx_rise),
      .fall_o ()
   );

   // ----------------------------------------------------------------
   // Transmit character analysis
   // ----------------------------------------------------------------
   function automatic logic is_ctl(input logic [7:0] c);
      is_ctl = (c == STX_CH) || (c == ETX_CH) || (c == ETB_CH) || (c == EOT_CH)
         || (c == DLE_CH) || (c == SYN_CH) || (c == ENQ_CH); // RULE20
   endfunction : is_ctl

   wire [7:0] h = hold.data;
   // Transparent text can carry any code, so only a tagged byte frames
   wire h_ctl = cfg.transp ? hold.ctl : is_ctl(h); // RULE20
   wire h_stx = h_ctl && (h == STX_CH);
   wire h_term = h_ctl && ((h == ETX_CH) || (h == ETB_CH));
   wire h_fill = (h == SYN_CH) || (h == PAD_CH);
   wire h_skip = cfg.transp ? (hold.ctl && h_fill) : h_fill; // RULE15
   wire needs_esc = cfg.transp && (hold.ctl || h == DLE_CH); // RULE17 RULE18

   // ----------------------------------------------------------------
   // Transmit sequencer
   // ----------------------------------------------------------------
   spla_txst_t tx_st;
   spla_txst_t next_st;
   logic [1:0] lead_cnt;
   logic [1:0] next_lead;
   logic in_text;
   logic next_text;
   logic [10:0] shreg;
   logic [3:0] bits_left;
   logic [15:0] crc;
   logic take;
   logic ld;
   logic send_h;
   logic crc_clr;
   logic crc_upd;
   logic tmo_go;
   logic [7:0] ch;

   wire bnd = tx_fall && (bits_left == 4'h0);

   always_comb begin
      take = 1'b0;
      ld = 1'b0;
      send_h = 1'b0;
      crc_clr = 1'b0;
      crc_upd = 1'b0;
      tmo_go = 1'b0;
      ch = SYN_CH;
      next_st = tx_st;
      next_lead = lead_cnt;
      next_text = in_text;
      case (tx_st)
         TX_IDLE: begin
            if (hold_full && tx_ok) begin
               ld = 1'b1;
               if (cfg.bisync) begin
                  next_st = TX_LEAD; // RULE10
                  next_lead = 2'h1;
               end else begin
                  take = 1'b1;
                  ch = h;
               end
            end
         end
         TX_LEAD: begin
            ld = 1'b1;
            next_lead = lead_cnt + 2'h1;
            if (lead_cnt == 2'(LEAD_SYNS - 1)) begin
               next_st = TX_RUN; // RULE10
            end
         end
         TX_RUN: begin
            if (hold_full) begin
               ld = 1'b1;
               if (needs_esc) begin
                  ch = DLE_CH; // RULE17 RULE18
                  next_st = TX_ESC;
               end else begin
                  send_h = 1'b1;
               end
            end else if (in_text) begin
               ld = 1'b1;
               ch = cfg.transp ? DLE_CH : SYN_CH; // RULE12 RULE17
               next_st = TX_FILL;
            end else begin
               next_st = TX_IDLE; // RULE11
               tmo_go = 1'b1; // RULE16
            end
         end
         TX_ESC: begin
            ld = 1'b1;
            send_h = 1'b1;
         end
         TX_FILL: begin
            ld = 1'b1; // RULE12
            next_st = TX_RUN;
         end
         TX_CRC1: begin
            ld = 1'b1;
            ch = crc[7:0]; // RULE14 RULE24
            next_st = TX_CRC2;
         end
         TX_CRC2: begin
            ld = 1'b1;
            ch = crc[15:8]; // RULE14 RULE24
            next_st = TX_RUN;
         end
         default: begin
            next_st = TX_IDLE;
         end
      endcase
      if (send_h) begin
         take = 1'b1;
         ch = h;
         next_st = TX_RUN;
         crc_upd = in_text && !h_skip; // RULE15
         if (!in_text && h_stx) begin
            next_text = 1'b1; // RULE14
            crc_clr = 1'b1;
         end
         if (in_text && h_term) begin
            next_text = 1'b0; // RULE14
            next_st = TX_CRC1;
         end
      end
   end

   spla_crc16 u_crc (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .clr_i (bnd && crc_clr),
      .upd_i (bnd && crc_upd),
      .byte_i (ch),
      .crc_o (crc)
   );

   // Character frames, least significant bit first
   wire par = (^ch[6:0]) ^ (ch[7] && !cfg.seven) ^ cfg.par_odd; // RULE21
   wire [10:0] frame = cfg.bisync ? {3'h7, ch}
      : (cfg.seven ? {2'h3, par, ch[6:0], 1'b0} : {1'b1, par, ch, 1'b0});
   wire [3:0] flen = cfg.bisync ? LEN_BSC : (cfg.seven ? LEN_A7 : LEN_A8);

   always_ff @(posedge clk_i) begin
      if (rst_i || !cfg.enable) begin
         tx_st <= TX_IDLE;
         lead_cnt <= 2'h0;
         in_text <= 1'b0;
         shreg <= 11'h7ff;
         bits_left <= 4'h0;
         link_txd_o <= 1'b1;
      end else if (bnd) begin
         tx_st <= next_st;
         lead_cnt <= next_lead;
         in_text <= next_text;
         shreg <= {1'b1, frame[10:1]};
         bits_left <= ld ? flen - 4'h1 : 4'h0;
         link_txd_o <= ld ? frame[0] : 1'b1; // RULE2 RULE3 RULE11
      end else if (tx_fall) begin
         shreg <= {1'b1, shreg[10:1]};
         bits_left <= bits_left - 4'h1;
         link_txd_o <= shreg[0]; // RULE3
      end
   end

   // ----------------------------------------------------------------
   // Receiver
   // ----------------------------------------------------------------
   logic [8:0] rx_sh;
   logic [3:0] rx_cnt;
   logic rx_act;

   // The far end idles at mark, so a space marks a start bit
   wire [8:0] rx_next = {rxd_s, rx_sh[8:1]}; // RULE1 RULE4
   wire [3:0] rx_nbits = cfg.seven ? RXB_A7 : RXB_A8;
   wire [7:0] bs_char = rx_next[8:1];
   wire bs_end = rx_act && (rx_cnt[2:0] == BSC_LAST);
   wire a_end = rx_act && (rx_cnt == rx_nbits);
   wire [7:0] a_char = cfg.seven ? rx_sh[8:1] : rx_sh[7:0]; // RULE22
   wire a_bad = cfg.rx_par_chk && (((cfg.seven ? ^rx_sh[8:1] : ^rx_sh) ^ cfg.par_odd) != 1'b0);
   // Responses go up raw; software validates them
   wire bs_put = bs_end && (bs_char != SYN_CH) && (bs_char != PAD_CH); // RULE8 RULE9
   wire rx_put = cfg.enable && rx_rise && (cfg.bisync ? bs_put : a_end);
   wire [7:0] rx_char = cfg.bisync ? bs_char : a_char;
   wire rx_perr = rx_put && !cfg.bisync && a_bad; // RULE21

   always_ff @(posedge clk_i) begin
      if (rst_i || !cfg.enable) begin
         rx_sh <= 9'h1ff;
         rx_cnt <= 4'h0;
         rx_act <= 1'b0;
      end else if (rx_rise) begin
         if (cfg.bisync) begin
            rx_sh <= rx_next; // RULE4
            if (!rx_act) begin
               rx_act <= (bs_char == SYN_CH);
               rx_cnt <= 4'h0;
            end else if (bs_end) begin
               rx_act <= (bs_char != PAD_CH);
               rx_cnt <= 4'h0;
            end else begin
               rx_cnt <= rx_cnt + 4'h1;
            end
         end else if (!rx_act) begin
            rx_act <= !rxd_s;
            rx_cnt <= 4'h0;
         end else if (a_end) begin
            rx_act <= 1'b0;
         end else begin
            rx_sh <= rx_next; // RULE4
            rx_cnt <= rx_cnt + 4'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Response time-out
   // ----------------------------------------------------------------
   logic tmo_arm;
   logic [31:0] tmo_cnt;
   wire tmo_hit = tmo_arm && (tmo_cnt == 32'(TIMEOUT_CYC - 1));

   always_ff @(posedge clk_i) begin
      if (rst_i || !cfg.enable || rx_put) begin
         tmo_arm <= 1'b0;
         tmo_cnt <= 32'h0;
      end else if (bnd && (tmo_go || next_st == TX_LEAD)) begin
         tmo_arm <= tmo_go; // RULE16
         tmo_cnt <= 32'h0;
      end else if (tmo_arm) begin
         tmo_arm <= !tmo_hit;
         tmo_cnt <= tmo_cnt + 32'h1;
      end
   end

   // ----------------------------------------------------------------
   // Registers and bus answer
   // ----------------------------------------------------------------
   wire tx_busy = (tx_st != TX_IDLE) || (bits_left != 4'h0);
   wire [31:0] stat = {22'h0, in_text, rts_s, dtr_s, !speed_ok, tmo_flag, ovr_flag,
      perr_flag, rx_valid, hold_full, tx_busy};
   wire [31:0] rdata = (wb_adr_i == REG_CTRL) ? {22'h0, cfg}
      : (wb_adr_i == REG_STAT) ? stat
      : (wb_adr_i == REG_RXD) ? {24'h0, rx_byte} : 32'h0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= (wb_req && !wb_we_i) ? rdata : 32'h0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg <= CTRL_RST;
      end else if (wr_ctrl) begin
         cfg[7:0] <= wb_sel_i[0] ? wb_dat_i[7:0] : cfg[7:0];
         cfg[9:8] <= wb_sel_i[1] ? wb_dat_i[9:8] : cfg[9:8];
      end
   end

   // A full holding word refuses further writes; software polls
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_full <= 1'b0;
         hold <= '0;
      end else if (wr_txd) begin
         hold_full <= 1'b1;
         hold <= {wb_sel_i[1] && wb_dat_i[TXD_CTL], wb_dat_i[7:0]};
      end else if (bnd && take) begin
         hold_full <= 1'b0;
      end
   end

   // Hardware set wins over a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_byte <= 8'h0;
         rx_valid <= 1'b0;
         perr_flag <= 1'b0;
         ovr_flag <= 1'b0;
         tmo_flag <= 1'b0;
      end else begin
         rx_byte <= rx_put ? rx_char : rx_byte;
         rx_valid <= rx_put || (rx_valid && !rd_rxd);
         perr_flag <= rx_perr || (perr_flag && !(wr_stat && wb_dat_i[ST_PERR]));
         ovr_flag <= (rx_put && rx_valid && !rd_rxd)
            || (ovr_flag && !(wr_stat && wb_dat_i[ST_OVR]));
         tmo_flag <= tmo_hit || (tmo_flag && !(wr_stat && wb_dat_i[ST_TMO])); // RULE16
      end
   end

   // Clear to send only answers a request, and drops while a byte waits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         link_cts_o <= 1'b0;
      end else begin
         link_cts_o <= cfg.enable && cfg.cts_en && rts_s && !rx_valid; // RULE6 RULE7
      end
   end

endmodule : spla_adapter

/* File: sim/spla_adapter_props.sv */
`timescale 1ns/10ps
module spla_adapter_props
   import spla_pkg::*;
#(
   parameter int CLK_HZ = 200_000_000,
   parameter int TIMEOUT_CYC = 200_000_000
) (
   // System
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Link
   input wire logic link_txd_o,
   input wire logic link_txclk_o,
   input wire logic link_rxclk_o,
   input wire logic link_rts_i,
   input wire logic link_cts_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_rts_gone;
      (!link_rts_i) [*4];
   endsequence
   chk_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack missing");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
      else $error("ack without request");
   chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not 0");
   chk_cts_rts: assert property (
      link_cts_o |-> $past(link_rts_i, 2) || $past(link_rts_i, 3)) else $error("cts early");
   chk_cts_drop: assert property (s_rts_gone |-> !link_cts_o) else $error("cts held");
   chk_txd_edge: assert property ($changed(link_txd_o) |-> !link_txclk_o)
      else $error("txd moved on high clock");
   chk_bit_hold: assert property (
      $changed(link_txd_o) |=> $stable(link_txd_o) [*3]) else $error("bit too short");
   chk_clk_pair: assert property (link_rxclk_o == link_txclk_o)
      else $error("bit clocks differ");
   chk_reset_idle: assert property ($fell(rst_i) |-> link_txd_o && !link_cts_o)
      else $error("line not idle");
endmodule : spla_adapter_props

bind spla_adapter spla_adapter_props #(.CLK_HZ(CLK_HZ), .TIMEOUT_CYC(TIMEOUT_CYC))
   spla_adapter_props_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_txd_o(link_txd_o),
   .link_txclk_o(link_txclk_o), .link_rxclk_o(link_rxclk_o), .link_rts_i(link_rts_i),
   .link_cts_o(link_cts_o));

/* File: sim/spla_plotter_model.sv */
`timescale 1ns/10ps
module spla_plotter_model (
   // Timing from the adapter
   input wire logic rxclk_i,
   input wire logic cts_i,
   // Bench control
   input wire logic go_i,
   input wire logic [10:0] frame_i,
   output logic busy_o,
   // Lines toward the adapter
   output logic rxd_o,
   output logic rts_o,
   output logic dtr_o
);
   initial begin
      rxd_o = 1'b1;
      rts_o = 1'b0;
      dtr_o = 1'b1;
      busy_o = 1'b0;
   end
   // Frame ends in mark bits, so the line rests at mark afterwards
   always @(posedge go_i) begin
      busy_o = 1'b1;
      rts_o = 1'b1;
      wait (cts_i === 1'b1);
      for (int i = 0; i < 11; i++) begin
         @(negedge rxclk_i);
         rxd_o = frame_i[i];
      end
      rts_o = 1'b0;
      busy_o = 1'b0;
   end
endmodule : spla_plotter_model

/* File: sim/testbench.sv */
`timescale 1ns/10ps
module testbench;
   import spla_pkg::*;
   localparam int TMO = 2000;
   localparam int BIT = 16;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic go = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [10:0] frame = 11'h7ff;
   logic [31:0] rdat;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, txd, rxd, txclk, rxclk, rts, dtr, cts, busy;
   logic bits[$];
   int miscompares = 0;
   int n_tests = 0;
   always #2.5 clk_i = ~clk_i;
   always @(posedge txclk) bits.push_back(txd);
   spla_adapter #(.CLK_HZ(153_600), .TIMEOUT_CYC(TMO)) spla_adapter_inst (.clk_i(clk_i),
      .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .link_txd_o(txd), .link_rxd_i(rxd), .link_txclk_o(txclk), .link_rxclk_o(rxclk),
      .link_rts_i(rts), .link_dtr_i(dtr), .link_cts_o(cts));
   spla_plotter_model spla_plotter_model_inst (.rxclk_i(rxclk), .cts_i(cts), .go_i(go),
      .frame_i(frame), .busy_o(busy), .rxd_o(rxd), .rts_o(rts), .dtr_o(dtr));
   // ----
   // Bus access and checking
   // ----
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) miscompares++;
      rdat = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task poll(input int b, input logic v);
      int n;
      n = 0;
      do begin
         wb(1'b0, REG_STAT, 32'h0);
         n++;
      end while (rdat[b] !== v && n < 3000);
      if (n >= 3000) miscompares++;
   endtask : poll
   task tx(input logic [8:0] w);
      poll(ST_HOLD, 1'b0);
      wb(1'b1, REG_TXD, {23'h0, w});
   endtask : tx
   task send(input logic [10:0] f);
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 200) miscompares++;
      frame <= f;
      go <= 1'b1;
      poll(ST_RXV, 1'b1);
      go <= 1'b0;
   endtask : send
   // Line bits from the first space on, least significant first
   function automatic logic [15:0] fld(input int off, input int n);
      int st;
      st = 0;
      while (st < bits.size() && bits[st] !== 1'b0) st++;
      fld = 16'h0;
      for (int i = 0; i < n; i++) fld[i] = (st + off + i < bits.size()) ? bits[st + off + i] : 1'bx;
   endfunction : fld
   function automatic logic [15:0] crc_up(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ CRC_POLY_REV) : (r >> 1);
      return r;
   endfunction : crc_up
   task test_done;
      $display("Checks %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   // ----
   // Tests
   // ----
   initial begin
      repeat (60000) @(posedge clk_i);
      miscompares++;
      test_done();
   end
   initial begin
      logic [7:0] e[$];
      logic [7:0] d;
      logic [15:0] c;
      logic p;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, REG_CTRL, 32'h0);
      chk(rdat, {22'h0, CTRL_RST});
      wb(1'b0, 8'h40, 32'h0);
      chk(rdat, 32'h0);
      wb(1'b0, REG_STAT, 32'h0);
      chk(rdat[ST_DTR], 1'b1);
      for (int s = 0; s < 16; s++) begin
         wb(1'b1, REG_CTRL, ((s % 8) << 7) | ((s / 8) << 1));
         wb(1'b0, REG_STAT, 32'h0);
         chk(rdat[ST_SPDBAD], (s / 8) ? (s % 8 < 2) : (s % 8 == 7));
      end
      $display("registers and speeds done");
      for (int q = 0; q < 2; q++) begin
         wb(1'b1, REG_CTRL, 32'h301 | (q * 32'h18));
         bits.delete();
         tx(9'h0a5);
         poll(ST_HOLD, 1'b0);
         poll(ST_BUSY, 1'b0);
         repeat (BIT * 2) @(posedge clk_i);
         chk(fld(0, 11), q ? {3'b110, 7'h25, 1'b0} : {2'b10, 8'ha5, 1'b0});
      end
      $display("async transmit done");
      wb(1'b1, REG_CTRL, 32'h369);
      for (int q = 0; q < 2; q++) begin
         p = (^7'h43) ^ q[0];
         send({2'b11, p, 7'h43, 1'b0});
         wb(1'b0, REG_STAT, 32'h0);
         chk(rdat[ST_PERR], q);
         wb(1'b0, REG_RXD, 32'h0);
         chk(rdat, {p, 7'h43});
         wb(1'b1, REG_STAT, 32'h8);
      end
      $display("async receive done");
      for (int t = 0; t < 2; t++) begin
         wb(1'b1, REG_CTRL, t ? 32'h307 : 32'h303);
         bits.delete();
         d = t ? DLE_CH : 8'h41;
         e = {SYN_CH, SYN_CH, SYN_CH, SYN_CH};
         if (t) e.push_back(DLE_CH);
         e.push_back(STX_CH);
         e.push_back(t ? DLE_CH : SYN_CH);
         e.push_back(SYN_CH);
         if (t) e.push_back(DLE_CH);
         e.push_back(d);
         if (t) e.push_back(DLE_CH);
         e.push_back(ETX_CH);
         c = crc_up(crc_up(CRC_INIT, d), ETX_CH);
         e.push_back(c[7:0]);
         e.push_back(c[15:8]);
         tx({t[0], STX_CH});
         poll(ST_HOLD, 1'b0);
         repeat (BIT * 10) @(posedge clk_i);
         tx({1'b0, d});
         tx({t[0], ETX_CH});
         poll(ST_BUSY, 1'b0);
         repeat (BIT * 10) @(posedge clk_i);
         foreach (e[k]) chk(fld(8 * k, 8), e[k]);
         chk(fld(8 * e.size(), 8), 8'hff);
         repeat (TMO) @(posedge clk_i);
         wb(1'b0, REG_STAT, 32'h0);
         chk(rdat[ST_TMO], 1'b1);
         wb(1'b1, REG_STAT, 32'h20);
      end
      $display("bisync transmit done");
      test_done();
   end
endmodule : testbench
